/* File: hdl/ssw_defines.svh */
// Timing constants for the supply supervisor watchdog.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef SSW_DEFINES_SVH
`define SSW_DEFINES_SVH

`define SSW_CLK_PERIOD_NS    20
`define SSW_NS_PER_MS        1000000
`define SSW_NS_PER_US        1000
`define SSW_MS_CYC           (`SSW_NS_PER_MS / `SSW_CLK_PERIOD_NS)
`define SSW_CYC_UP(ns)       (((ns) + `SSW_CLK_PERIOD_NS - 1) / `SSW_CLK_PERIOD_NS)
`define SSW_CYC_DN(ns)       ((ns) / `SSW_CLK_PERIOD_NS)

// Nominal durations, build-option values
`define SSW_RESET_HOLD_MS    200
`define SSW_KICK_WINDOW_MS   1600
`define SSW_STARTUP_MS       2000
`define SSW_ALARM_PULSE_MS   200
`define SSW_ALARM_MIN_MS     100
`define SSW_ALARM_MAX_MS     300
`define SSW_SETUP_US         300
`define SSW_KICK_MIN_US      1
`define SSW_ALLOW_GLITCH_NS  300
`define SSW_MR_GLITCH_NS     200
`define SSW_MR_DELAY_NS      250

// Filter and output reset levels, and counter constants
`define SSW_LVL_HIGH         1'b1
`define SSW_LVL_LOW          1'b0
`define SSW_CNT_ZERO         32'h0000_0000
`define SSW_CNT_ONE          32'h0000_0001
`define SSW_CNT_MAX          32'hffff_ffff

`endif

/* File: hdl/ssw_pkg.sv */
// Types for the supply supervisor watchdog.
// Needs no other file.
package ssw_pkg;

  typedef enum logic [2:0] {
    SSW_WD_OFF   = 3'b000,
    SSW_WD_START = 3'b001,
    SSW_WD_DIS   = 3'b010,
    SSW_WD_SETUP = 3'b011,
    SSW_WD_RUN   = 3'b100,
    SSW_WD_ALARM = 3'b101
  } ssw_wd_state_e;

  typedef struct packed {
    logic sys_reset_n;
    logic wd_alarm_n;
  } ssw_out_s;

  typedef logic [31:0] ssw_cnt_t;

endpackage

/* File: hdl/ssw_filter.sv */
// Glitch filter: output follows input only after it differs for STABLE_CYC cycles.
// Assumes the input is synchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "ssw_defines.svh"

module ssw_filter #(
  parameter int unsigned STABLE_CYC = 15,
  parameter bit          RST_VAL    = 1'b0
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Level in and filtered level out
  input  wire logic d_i,
  output var  logic q_o
);

  localparam int unsigned CW = $clog2(STABLE_CYC + 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          nxt_q;
  wire           differs = (d_i != q_o);
  wire           settled = (cnt_ff == CW'(STABLE_CYC - 1));

  assign nxt_cnt = (!differs || settled) ? '0 : cnt_ff + CW'(1);
  assign nxt_q   = (differs && settled) ? d_i : q_o;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= '0;
      q_o    <= RST_VAL;
    end else begin
      cnt_ff <= nxt_cnt;
      q_o    <= nxt_q;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/ssw_supervisor.sv */
// Supply supervisor with watchdog: reset generator, kick monitor and alarm pulse.
// Assumes all inputs synchronous to CLOCK_I; undervoltage comes from an outside comparator.
`timescale 1ns/1ns
`default_nettype none
`include "ssw_defines.svh"

module ssw_supervisor #(
  parameter bit          MR_OPTION     = 1'b1,
  parameter int unsigned RESET_HOLD_CYC = `SSW_RESET_HOLD_MS * `SSW_MS_CYC,
  parameter int unsigned KICK_CYC       = `SSW_KICK_WINDOW_MS * `SSW_MS_CYC,
  parameter int unsigned STARTUP_CYC    = `SSW_STARTUP_MS * `SSW_MS_CYC,
  parameter int unsigned ALARM_CYC      = `SSW_ALARM_PULSE_MS * `SSW_MS_CYC,
  parameter int unsigned SETUP_CYC      = `SSW_CYC_UP(`SSW_SETUP_US * `SSW_NS_PER_US)
) (
  // Clock and reset
  input  wire logic CLOCK_I,
  input  wire logic ARST_N_I,
  // Supply and processor inputs
  input  wire logic UNDERVOLT_I,
  input  wire logic MANUAL_RESET_N_I,
  input  wire logic WD_ALLOW_I,
  input  wire logic KICK_IN_I,
  // Active-low outputs
  output var  logic SYS_RESET_N_O,
  output var  logic WD_ALARM_N_O
);

  localparam int unsigned KICK_MIN_CYC = `SSW_CYC_UP(`SSW_KICK_MIN_US * `SSW_NS_PER_US);
  localparam int unsigned ALLOW_CYC    = `SSW_CYC_UP(`SSW_ALLOW_GLITCH_NS);
  localparam int unsigned MRD_CYC      = `SSW_CYC_DN(`SSW_MR_DELAY_NS);

  ssw_pkg::ssw_out_s      out_ff;
  ssw_pkg::ssw_out_s      nxt_out;
  ssw_pkg::ssw_wd_state_e state_ff;
  ssw_pkg::ssw_wd_state_e nxt_state;
  ssw_pkg::ssw_cnt_t      hold_cnt_ff;
  ssw_pkg::ssw_cnt_t      nxt_hold_cnt;
  ssw_pkg::ssw_cnt_t      wd_cnt_ff;
  ssw_pkg::ssw_cnt_t      nxt_wd_cnt;
  logic                   kick_prev_ff;
  logic                   mr_filt;
  logic                   allow_filt;
  logic                   kick_filt;

  ////////////////////////////////////////////////////////////////////////////////
  // Input filters
  ssw_filter #(.STABLE_CYC(MRD_CYC), .RST_VAL(`SSW_LVL_HIGH)) u_mr_filt (
    .clk_i    (CLOCK_I),
    .arst_n_i (ARST_N_I),
    .d_i      (MANUAL_RESET_N_I),
    .q_o      (mr_filt)
  );

  ssw_filter #(.STABLE_CYC(ALLOW_CYC), .RST_VAL(`SSW_LVL_LOW)) u_allow_filt (
    .clk_i    (CLOCK_I),
    .arst_n_i (ARST_N_I),
    .d_i      (WD_ALLOW_I),
    .q_o      (allow_filt)
  );

  ssw_filter #(.STABLE_CYC(KICK_MIN_CYC), .RST_VAL(`SSW_LVL_LOW)) u_kick_filt (
    .clk_i    (CLOCK_I),
    .arst_n_i (ARST_N_I),
    .d_i      (KICK_IN_I),
    .q_o      (kick_filt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // System reset generator
  wire mr_low    = MR_OPTION && !mr_filt;
  wire hold_cond = UNDERVOLT_I || mr_low;
  wire hold_done = (hold_cnt_ff == RESET_HOLD_CYC - 1);

  assign nxt_hold_cnt = hold_cond ? `SSW_CNT_ZERO :
                        (hold_done || out_ff.sys_reset_n) ? hold_cnt_ff :
                        hold_cnt_ff + `SSW_CNT_ONE;
  assign nxt_out.sys_reset_n = !hold_cond && (hold_done || out_ff.sys_reset_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  wire wd_allow      = MR_OPTION || allow_filt;
  wire kick_fall  = kick_prev_ff && !kick_filt;
  wire start_done = (wd_cnt_ff == STARTUP_CYC - 1);
  wire setup_done = (wd_cnt_ff == SETUP_CYC - 1);
  wire kick_done  = (wd_cnt_ff == KICK_CYC - 1);
  wire alarm_done = (wd_cnt_ff == ALARM_CYC - 1);

  always_comb begin
    nxt_state  = state_ff;
    nxt_wd_cnt = wd_cnt_ff + `SSW_CNT_ONE;
    if (!out_ff.sys_reset_n) begin
      nxt_state  = ssw_pkg::SSW_WD_OFF;
      nxt_wd_cnt = `SSW_CNT_ZERO;
    end else begin
      case (state_ff)
        ssw_pkg::SSW_WD_OFF: begin
          nxt_state  = ssw_pkg::SSW_WD_START;
          nxt_wd_cnt = `SSW_CNT_ZERO;
        end
        ssw_pkg::SSW_WD_START: begin
          if (start_done) begin
            nxt_state  = wd_allow ? ssw_pkg::SSW_WD_RUN : ssw_pkg::SSW_WD_DIS;
            nxt_wd_cnt = `SSW_CNT_ZERO;
          end
        end
        ssw_pkg::SSW_WD_DIS: begin
          nxt_wd_cnt = `SSW_CNT_ZERO;
          if (wd_allow) begin
            nxt_state = ssw_pkg::SSW_WD_SETUP;
          end
        end
        ssw_pkg::SSW_WD_SETUP: begin
          if (!wd_allow) begin
            nxt_state  = ssw_pkg::SSW_WD_DIS;
            nxt_wd_cnt = `SSW_CNT_ZERO;
          end else if (setup_done) begin
            nxt_state  = ssw_pkg::SSW_WD_RUN;
            nxt_wd_cnt = `SSW_CNT_ZERO;
          end
        end
        ssw_pkg::SSW_WD_RUN: begin
          if (!wd_allow) begin
            nxt_state  = ssw_pkg::SSW_WD_DIS;
            nxt_wd_cnt = `SSW_CNT_ZERO;
          end else if (kick_fall) begin
            nxt_wd_cnt = `SSW_CNT_ZERO;
          end else if (kick_done) begin
            nxt_state  = ssw_pkg::SSW_WD_ALARM;
            nxt_wd_cnt = `SSW_CNT_ZERO;
          end
        end
        ssw_pkg::SSW_WD_ALARM: begin
          if (!wd_allow) begin
            nxt_state  = ssw_pkg::SSW_WD_DIS;
            nxt_wd_cnt = `SSW_CNT_ZERO;
          end else if (alarm_done) begin
            nxt_state  = ssw_pkg::SSW_WD_RUN;
            nxt_wd_cnt = `SSW_CNT_ZERO;
          end
        end
        default: begin
          nxt_state  = ssw_pkg::SSW_WD_OFF;
          nxt_wd_cnt = `SSW_CNT_ZERO;
        end
      endcase
    end
  end

  assign nxt_out.wd_alarm_n = (nxt_state != ssw_pkg::SSW_WD_ALARM);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      out_ff.sys_reset_n <= `SSW_LVL_LOW;
      out_ff.wd_alarm_n  <= `SSW_LVL_HIGH;
      state_ff           <= ssw_pkg::SSW_WD_OFF;
      hold_cnt_ff        <= `SSW_CNT_ZERO;
      wd_cnt_ff          <= `SSW_CNT_ZERO;
      kick_prev_ff       <= `SSW_LVL_LOW;
    end else begin
      out_ff       <= nxt_out;
      state_ff     <= nxt_state;
      hold_cnt_ff  <= nxt_hold_cnt;
      wd_cnt_ff    <= nxt_wd_cnt;
      kick_prev_ff <= kick_filt;
    end
  end

  assign SYS_RESET_N_O = out_ff.sys_reset_n;
  assign WD_ALARM_N_O  = out_ff.wd_alarm_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  ssw_pkg::ssw_cnt_t quiet_ff;
  ssw_pkg::ssw_cnt_t alarm_len_ff;

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      quiet_ff     <= `SSW_CNT_ZERO;
      alarm_len_ff <= `SSW_CNT_ZERO;
    end else begin
      quiet_ff     <= hold_cond ? `SSW_CNT_ZERO :
                      (quiet_ff == `SSW_CNT_MAX) ? quiet_ff : quiet_ff + `SSW_CNT_ONE;
      alarm_len_ff <= WD_ALARM_N_O ? `SSW_CNT_ZERO : alarm_len_ff + `SSW_CNT_ONE;
    end
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);

  property p_uv_holds;
    UNDERVOLT_I |=> !SYS_RESET_N_O;
  endproperty
  a_uv_holds: assert property (p_uv_holds) else $error("reset not held in undervoltage");

  property p_hold_time;
    $rose(SYS_RESET_N_O) |-> quiet_ff == RESET_HOLD_CYC;
  endproperty
  a_hold_time: assert property (p_hold_time) else $error("reset hold time wrong");

  property p_alarm_cause;
    $fell(WD_ALARM_N_O) |-> $past(state_ff) == ssw_pkg::SSW_WD_RUN && $past(kick_done);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without timeout");

  property p_alarm_width;
    $rose(WD_ALARM_N_O) && $past(wd_allow) && $past(SYS_RESET_N_O) |-> alarm_len_ff == ALARM_CYC;
  endproperty
  a_alarm_width: assert property (p_alarm_width) else $error("alarm pulse width wrong");

  property p_mr_holds;
    mr_low |=> !SYS_RESET_N_O;
  endproperty
  a_mr_holds: assert property (p_mr_holds) else $error("reset not held by manual reset");

  property p_mr_glitch;
    (SYS_RESET_N_O && !UNDERVOLT_I && $fell(MANUAL_RESET_N_I))
      ##1 (MANUAL_RESET_N_I && !UNDERVOLT_I)[*8] |-> SYS_RESET_N_O;
  endproperty
  a_mr_glitch: assert property (p_mr_glitch) else $error("manual reset glitch caused reset");

  property p_mr_delay;
    MR_OPTION && $fell(MANUAL_RESET_N_I) ##0 (!MANUAL_RESET_N_I)[*8] ##1 (!MANUAL_RESET_N_I)[*7]
      |=> !SYS_RESET_N_O;
  endproperty
  a_mr_delay: assert property (p_mr_delay) else $error("manual reset did not assert reset");

  property p_startup;
    $rose(SYS_RESET_N_O) |=> state_ff == ssw_pkg::SSW_WD_START && wd_cnt_ff == `SSW_CNT_ZERO;
  endproperty
  a_startup: assert property (p_startup) else $error("startup not begun at reset release");

  property p_startup_len;
    state_ff == ssw_pkg::SSW_WD_START && nxt_state != ssw_pkg::SSW_WD_START && SYS_RESET_N_O
      |-> start_done;
  endproperty
  a_startup_len: assert property (p_startup_len) else $error("startup delay wrong");

  property p_setup_len;
    state_ff == ssw_pkg::SSW_WD_SETUP && nxt_state == ssw_pkg::SSW_WD_RUN |-> wd_cnt_ff == SETUP_CYC - 1;
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("setup time wrong");

  property p_disable;
    !wd_allow && SYS_RESET_N_O |=> WD_ALARM_N_O && state_ff != ssw_pkg::SSW_WD_RUN;
  endproperty
  a_disable: assert property (p_disable) else $error("watchdog active while disabled");

  property p_allow_glitch;
    (!allow_filt && $rose(WD_ALLOW_I)) ##1 !WD_ALLOW_I |=> (!allow_filt)[*4];
  endproperty
  a_allow_glitch: assert property (p_allow_glitch) else $error("allow glitch passed");

  property p_kick_restart;
    state_ff == ssw_pkg::SSW_WD_RUN && wd_allow && SYS_RESET_N_O && kick_fall |=> wd_cnt_ff == `SSW_CNT_ZERO;
  endproperty
  a_kick_restart: assert property (p_kick_restart) else $error("kick did not restart timer");

  c_alarm: cover property ($rose(WD_ALARM_N_O));
  c_manual: cover property (mr_low ##1 !SYS_RESET_N_O);
  c_setup_run: cover property (state_ff == ssw_pkg::SSW_WD_SETUP ##1 state_ff == ssw_pkg::SSW_WD_RUN);
  c_kick: cover property (state_ff == ssw_pkg::SSW_WD_RUN && kick_fall);

endmodule
`default_nettype wire

/* File: verification/ssw_cpu_model.sv */
// Behavioural model of the supervised processor that drives the kick line.
// Assumes one clock shared with the supervisor; the mode is set by the testbench.
`timescale 1ns/1ns
`default_nettype none

module ssw_cpu_model (
  // Clock
  input  wire logic       clk_i,
  // 0: hold, 1: proper kicks, 2: pulses too narrow to count
  input  wire logic [1:0] mode_i,
  // Kick line to the supervisor
  output var  logic       kick_o
);
  logic [6:0] cnt_ff = 7'h00;
  logic       kick_ff = 1'b1;

  // One procedural driver for the kick level; the port only follows it
  assign kick_o = kick_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode 1 toggles every 60 cycles: a falling edge every 120 cycles, each level 1.2 us wide
  always @(posedge clk_i) begin
    cnt_ff <= (cnt_ff == 7'h3b) ? 7'h00 : cnt_ff + 7'h01;
    if (mode_i == 2'h1 && cnt_ff == 7'h3b) begin
      kick_ff <= #2 ~kick_ff;
    end else if (mode_i == 2'h2) begin
      kick_ff <= #2 (cnt_ff >= 7'h0a);
    end
  end
endmodule

`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking testbench: manual reset build as u_dut, enable build as u_dut_en.
// Assumes ssw_supervisor and ssw_cpu_model are compiled first; counts are shortened.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  localparam int H   = 20;
  localparam int K   = 200;
  localparam int S   = 40;
  localparam int A   = 30;
  localparam int SU  = 25;
  localparam int DLY = 2;

  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       uv = 1'b0;
  logic       mr_n = 1'b1;
  logic       allow = 1'b0;
  logic [1:0] mode = 2'h0;
  logic       kick;
  logic       rst_n;
  logic       alarm_n;
  logic       rst_en_n;
  logic       alarm_en_n;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  int         n;

  ssw_cpu_model u_cpu (.clk_i(clk), .mode_i(mode), .kick_o(kick));

  ssw_supervisor #(.MR_OPTION(1'b1), .RESET_HOLD_CYC(H), .KICK_CYC(K), .STARTUP_CYC(S),
    .ALARM_CYC(A), .SETUP_CYC(SU)) u_dut (
    .CLOCK_I(clk), .ARST_N_I(arst_n), .UNDERVOLT_I(uv), .MANUAL_RESET_N_I(mr_n),
    .WD_ALLOW_I(1'b0), .KICK_IN_I(kick), .SYS_RESET_N_O(rst_n), .WD_ALARM_N_O(alarm_n));

  ssw_supervisor #(.MR_OPTION(1'b0), .RESET_HOLD_CYC(H), .KICK_CYC(K), .STARTUP_CYC(S),
    .ALARM_CYC(A), .SETUP_CYC(SU)) u_dut_en (
    .CLOCK_I(clk), .ARST_N_I(arst_n), .UNDERVOLT_I(1'b0), .MANUAL_RESET_N_I(1'b1),
    .WD_ALLOW_I(allow), .KICK_IN_I(kick), .SYS_RESET_N_O(rst_en_n), .WD_ALARM_N_O(alarm_en_n));

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #(DLY);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // Cycles until the signal reaches the level, at most lim
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (s !== v && cnt < lim) begin
      step(1);
      cnt++;
    end
  endtask

  // Cycles within c on which the signal was not high
  task automatic count_low(ref logic s, input int c, output int lows);
    lows = 0;
    repeat (c) begin
      step(1);
      if (s !== 1'b1) lows++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_release;
    wait_lvl(rst_n, 1'b1, 100, n);
    chk_rng(n, H - 1, H + 1);
    chk(alarm_n, 1'b1);
    $display("test reset_release done");
  endtask

  task automatic t_undervolt;
    uv = 1'b1;
    step(1);
    chk(rst_n, 1'b0);
    step(10);
    chk(rst_n, 1'b0);
    uv = 1'b0;
    wait_lvl(rst_n, 1'b1, 100, n);
    chk_rng(n, H - 1, H + 1);
    $display("test undervolt done");
  endtask

  task automatic t_mr_glitch;
    // Single-cycle dip first, then a longer one still under the filter length
    mr_n = 1'b0;
    step(1);
    mr_n = 1'b1;
    step(10);
    mr_n = 1'b0;
    step(5);
    mr_n = 1'b1;
    count_low(rst_n, 20, n);
    chk(n, 0);
    $display("test mr_glitch done");
  endtask

  task automatic t_mr_press;
    mr_n = 1'b0;
    wait_lvl(rst_n, 1'b0, 40, n);
    chk_rng(n, 11, 14);
    step(40);
    chk(rst_n, 1'b0);
    mr_n = 1'b1;
    wait_lvl(rst_n, 1'b1, 100, n);
    chk_rng(n, H + 10, H + 14);
    $display("test mr_press done");
  endtask

  task automatic t_startup_alarm;
    wait_lvl(alarm_n, 1'b0, 1000, n);
    chk_rng(n, 1 + S + K - 3, 1 + S + K + 3);
    wait_lvl(alarm_n, 1'b1, 200, n);
    chk_rng(n, A - 1, A + 1);
    $display("test startup_alarm done");
  endtask

  task automatic t_kick_ok;
    mode = 2'h1;
    count_low(alarm_n, 800, n);
    chk(n, 0);
    $display("test kick_ok done");
  endtask

  task automatic t_narrow;
    mode = 2'h2;
    wait_lvl(alarm_n, 1'b0, 600, n);
    chk_rng(n, 1, K + 130);
    mode = 2'h0;
    step(A + 5);
    $display("test narrow done");
  endtask

  task automatic t_enable;
    count_low(alarm_en_n, 300, n);
    chk(n, 0);
    allow = 1'b1;
    step(1);
    allow = 1'b0;
    step(2);
    allow = 1'b1;
    step(5);
    allow = 1'b0;
    count_low(alarm_en_n, 300, n);
    chk(n, 0);
    allow = 1'b1;
    wait_lvl(alarm_en_n, 1'b0, 600, n);
    chk_rng(n, 16 + SU + K - 4, 16 + SU + K + 4);
    allow = 1'b0;
    wait_lvl(alarm_en_n, 1'b1, 40, n);
    chk_rng(n, 1, 20);
    $display("test enable done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    step(8);
    arst_n = 1'b1;
    t_reset_release();
    t_undervolt();
    t_mr_glitch();
    t_mr_press();
    t_startup_alarm();
    t_kick_ok();
    t_narrow();
    t_enable();
    end_of_test();
  end

  initial begin
    #(20000 * 20);
    n_mismatch++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_of_test();
  end
endmodule

`default_nettype wire
